/* File: src/cbcm_pkg.sv */
package cbcm_pkg;

   // Opcode that selects the second page of the opcode table.
   localparam logic [7:0] OPC_PAGE2 = 8'h9E;
   // Page that holds the interrupt and reset vectors.
   localparam logic [7:0] VEC_PAGE = 8'hFF;
   // Page that holds direct-page operands.
   localparam logic [7:0] DIR_PAGE = 8'h00;

   localparam int TBL_DEPTH = 512;
   localparam int TBL_IDX_W = 9;
   localparam int ENTRY_W = 19;
   localparam int OPND_MAX = 3;

   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] SP_RST = 16'h00FF;
   localparam logic [15:0] HX_RST = 16'h0000;

   typedef enum logic [3:0] {
      MODE_INH = 4'h0,
      MODE_IMM = 4'h1,
      MODE_DIR = 4'h2,
      MODE_EXT = 4'h3,
      MODE_IX = 4'h4,
      MODE_IDX_BYTE = 4'h5,
      MODE_IDX_WORD = 4'h6,
      MODE_IDX_INC = 4'h7,
      MODE_IDX_BYTE_INC = 4'h8,
      MODE_REL = 4'h9,
      MODE_STK_BYTE = 4'hA,
      MODE_STK_WORD = 4'hB,
      MODE_DD = 4'hC,
      MODE_DIXP = 4'hD,
      MODE_IMD = 4'hE,
      MODE_IXPD = 4'hF
   } cbcm_mode_t;

   typedef enum logic [2:0] {
      CMD_FETCH = 3'h0,
      CMD_READ = 3'h1,
      CMD_WRITE = 3'h2,
      CMD_PUSH = 3'h3,
      CMD_POP = 3'h4,
      CMD_VECTOR = 3'h5,
      CMD_FREE = 3'h6,
      CMD_LOAD = 3'h7
   } cbcm_cmd_t;

   typedef enum logic [1:0] {
      LD_PC = 2'h0,
      LD_SP = 2'h1,
      LD_HX = 2'h2
   } cbcm_load_t;

   typedef struct packed {
      logic [7:0] opClass;
      cbcm_mode_t mode;
      logic [2:0] len;
      logic [3:0] cycles;
   } cbcm_entry_t;

   localparam cbcm_entry_t ENTRY_RST = '0;

endpackage : cbcm_pkg

/* File: src/cbcm_link_if.sv */
`timescale 1ns/1ps
interface cbcm_link_if;
   logic wrEn;
   logic [cbcm_pkg::TBL_IDX_W-1:0] wrIdx;
   cbcm_pkg::cbcm_entry_t wrData;
   logic [cbcm_pkg::TBL_IDX_W-1:0] rdIdx;
   cbcm_pkg::cbcm_entry_t rdEntry;
   cbcm_pkg::cbcm_mode_t mode;
   logic [15:0] hx;
   logic [15:0] sp;
   logic [15:0] pc;
   logic [7:0] opnd0;
   logic [7:0] opnd1;
   logic [7:0] relByte;
   logic [15:0] ea;
   logic [15:0] target;

   modport seq (output wrEn, wrIdx, wrData, rdIdx, mode, hx, sp, pc, opnd0, opnd1, relByte,
                input rdEntry, ea, target);
   modport store (input wrEn, wrIdx, wrData, rdIdx, output rdEntry);
   modport agu (input mode, hx, sp, pc, opnd0, opnd1, relByte, output ea, target);
endinterface : cbcm_link_if

/* File: src/cbcm_op_table.sv */
`timescale 1ns/1ps
module cbcm_op_table (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   cbcm_link_if.store lnk
);
   cbcm_pkg::cbcm_entry_t mem [cbcm_pkg::TBL_DEPTH];

   // Entries come from the loader, so the decode never guesses encodings.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < cbcm_pkg::TBL_DEPTH; i++) begin
            mem[i] <= cbcm_pkg::ENTRY_RST;
         end
      end else if (clkEn && lnk.wrEn) begin
         mem[lnk.wrIdx] <= lnk.wrData;
      end
   end

   assign lnk.rdEntry = mem[lnk.rdIdx];

endmodule : cbcm_op_table

/* File: src/cbcm_agu.sv */
`timescale 1ns/1ps
module cbcm_agu (
   cbcm_link_if.agu lnk
);
   logic [15:0] off8;
   logic [15:0] off16;
   logic [15:0] relExt;

   always_comb begin
      off8 = {8'h00, lnk.opnd0};
      off16 = {lnk.opnd0, lnk.opnd1};
      relExt = {{8{lnk.relByte[7]}}, lnk.relByte};
      // The program counter already points past the instruction here.
      lnk.target = lnk.pc + relExt;
      case (lnk.mode)
         cbcm_pkg::MODE_DIR, cbcm_pkg::MODE_DD, cbcm_pkg::MODE_DIXP: begin
            lnk.ea = {cbcm_pkg::DIR_PAGE, lnk.opnd0};
         end
         cbcm_pkg::MODE_IMD: begin
            lnk.ea = {cbcm_pkg::DIR_PAGE, lnk.opnd1};
         end
         cbcm_pkg::MODE_EXT: begin
            lnk.ea = off16;
         end
         cbcm_pkg::MODE_IX, cbcm_pkg::MODE_IDX_INC, cbcm_pkg::MODE_IXPD: begin
            lnk.ea = lnk.hx;
         end
         cbcm_pkg::MODE_IDX_BYTE, cbcm_pkg::MODE_IDX_BYTE_INC: begin
            lnk.ea = lnk.hx + off8;
         end
         cbcm_pkg::MODE_IDX_WORD: begin
            lnk.ea = lnk.hx + off16;
         end
         cbcm_pkg::MODE_STK_BYTE: begin
            lnk.ea = lnk.sp + off8;
         end
         cbcm_pkg::MODE_STK_WORD: begin
            lnk.ea = lnk.sp + off16;
         end
         cbcm_pkg::MODE_REL: begin
            lnk.ea = lnk.target;
         end
         default: begin
            lnk.ea = 16'h0000;
         end
      endcase
   end

endmodule : cbcm_agu

/* File: src/cbcm_decode_top.sv */
`timescale 1ns/1ps
module cbcm_decode_top (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic tblWrEn,
   input wire logic [8:0] tblWrIdx,
   input wire logic [18:0] tblWrData,
   input wire logic cmdValid,
   input wire logic [2:0] cmdKind,
   input wire logic [7:0] cmdData,
   input wire logic [15:0] cmdValue,
   output logic cmdReady,
   output logic [15:0] busAddr,
   output logic busRead,
   output logic busWrite,
   output logic [7:0] busWdata,
   input wire logic [7:0] busRdata,
   output logic decValid,
   output logic [7:0] decOpClass,
   output logic [3:0] decMode,
   output logic [2:0] decLen,
   output logic [3:0] decCycles,
   output logic decPage2,
   output logic [15:0] decEa,
   output logic [15:0] decTarget,
   output logic readValid,
   output logic [7:0] readData,
   output logic [15:0] pcOut,
   output logic [15:0] spOut,
   output logic [15:0] hxOut
);

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_OPC = 4'h1,
      ST_OPND = 4'h2,
      ST_DONE = 4'h3,
      ST_READ = 4'h4,
      ST_WRITE = 4'h5,
      ST_PUSH = 4'h6,
      ST_POP = 4'h7,
      ST_VECHI = 4'h8,
      ST_VECLO = 4'h9,
      ST_FREE = 4'hA
   } cbcm_state_t;

   cbcm_state_t state_ff;
   logic [15:0] pc_ff;
   logic [15:0] sp_ff;
   logic [15:0] hx_ff;
   logic [7:0] data_ff;
   logic [7:0] vecHi_ff;
   logic page2_ff;
   logic incPend_ff;
   cbcm_pkg::cbcm_entry_t ent_ff;
   logic [7:0] opnd_ff [cbcm_pkg::OPND_MAX];
   logic [1:0] opndIdx_ff;
   logic [1:0] opndTot_ff;
   logic decValid_ff;
   logic [15:0] decEa_ff;
   logic [15:0] decTarget_ff;
   logic readValid_ff;
   logic [7:0] readData_ff;

   logic take;
   cbcm_pkg::cbcm_cmd_t cmd;
   logic [2:0] prefixLen;
   logic [1:0] opndCount;
   logic isPage2Prefix;
   logic postInc;

   cbcm_link_if lnk();

   cbcm_op_table uTable (
      .clock(clock),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .lnk(lnk.store)
   );

   cbcm_agu uAgu (
      .lnk(lnk.agu)
   );

   assign cmdReady = (state_ff == ST_IDLE);
   assign take = clkEn && cmdValid && cmdReady;
   assign cmd = cbcm_pkg::cbcm_cmd_t'(cmdKind);

   assign lnk.wrEn = tblWrEn;
   assign lnk.wrIdx = tblWrIdx;
   assign lnk.wrData = cbcm_pkg::cbcm_entry_t'(tblWrData);
   assign lnk.rdIdx = {page2_ff, busRdata};
   assign lnk.mode = ent_ff.mode;
   assign lnk.hx = hx_ff;
   assign lnk.sp = sp_ff;
   assign lnk.pc = pc_ff;
   assign lnk.opnd0 = opnd_ff[0];
   assign lnk.opnd1 = opnd_ff[1];

   // The branch offset is the last operand byte of the instruction, or zero when it has no operands.
   always_comb begin
      if (opndTot_ff == 2'h0) begin
         lnk.relByte = 8'h00;
      end else begin
         lnk.relByte = opnd_ff[opndTot_ff - 2'h1];
      end
   end

   assign isPage2Prefix = (busRdata == cbcm_pkg::OPC_PAGE2) && !page2_ff;

   // Operand bytes follow from the table length minus the opcode bytes.
   always_comb begin
      prefixLen = page2_ff ? 3'h2 : 3'h1;
      if (lnk.rdEntry.len > prefixLen) begin
         opndCount = 2'((lnk.rdEntry.len - prefixLen));
      end else begin
         opndCount = 2'h0;
      end
   end

   always_comb begin
      case (ent_ff.mode)
         cbcm_pkg::MODE_IDX_INC, cbcm_pkg::MODE_IDX_BYTE_INC: postInc = 1'b1;
         cbcm_pkg::MODE_DIXP, cbcm_pkg::MODE_IXPD: postInc = 1'b1;
         default: postInc = 1'b0;
      endcase
   end

   // Sequencer: each busy state but ST_DONE is one bus cycle; ST_OPC and ST_OPND repeat once per byte.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_ff <= ST_IDLE;
      end else if (clkEn) begin
         case (state_ff)
            ST_IDLE: begin
               if (take) begin
                  case (cmd)
                     cbcm_pkg::CMD_FETCH: state_ff <= ST_OPC;
                     cbcm_pkg::CMD_READ: state_ff <= ST_READ;
                     cbcm_pkg::CMD_WRITE: state_ff <= ST_WRITE;
                     cbcm_pkg::CMD_PUSH: state_ff <= ST_PUSH;
                     cbcm_pkg::CMD_POP: state_ff <= ST_POP;
                     cbcm_pkg::CMD_VECTOR: state_ff <= ST_VECHI;
                     cbcm_pkg::CMD_FREE: state_ff <= ST_FREE;
                     default: state_ff <= ST_IDLE;
                  endcase
               end
            end
            ST_OPC: begin
               if (isPage2Prefix) begin
                  state_ff <= ST_OPC;
               end else if (opndCount == 2'h0) begin
                  state_ff <= ST_DONE;
               end else begin
                  state_ff <= ST_OPND;
               end
            end
            ST_OPND: begin
               if (opndIdx_ff + 2'h1 == opndTot_ff) begin
                  state_ff <= ST_DONE;
               end
            end
            ST_VECHI: state_ff <= ST_VECLO;
            ST_DONE, ST_READ, ST_WRITE, ST_PUSH, ST_POP, ST_VECLO, ST_FREE: begin
               state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Program counter: one step per fetched byte, loads from vector or core.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pc_ff <= cbcm_pkg::PC_RST;
         vecHi_ff <= 8'h00;
      end else if (clkEn) begin
         if (state_ff == ST_OPC || state_ff == ST_OPND) begin
            pc_ff <= pc_ff + 16'h0001;
         end else if (state_ff == ST_VECHI) begin
            vecHi_ff <= busRdata;
         end else if (state_ff == ST_VECLO) begin
            pc_ff <= {vecHi_ff, busRdata};
         end else if (take && cmd == cbcm_pkg::CMD_LOAD && cmdData[1:0] == cbcm_pkg::LD_PC) begin
            pc_ff <= cmdValue;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         sp_ff <= cbcm_pkg::SP_RST;
      end else if (clkEn) begin
         if (state_ff == ST_PUSH) begin
            sp_ff <= sp_ff - 16'h0001;
         end else if (state_ff == ST_POP) begin
            sp_ff <= sp_ff + 16'h0001;
         end else if (take && cmd == cbcm_pkg::CMD_LOAD && cmdData[1:0] == cbcm_pkg::LD_SP) begin
            sp_ff <= cmdValue;
         end
      end
   end

   // The index steps after the first operand access of a post-increment mode.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         hx_ff <= cbcm_pkg::HX_RST;
         incPend_ff <= 1'b0;
      end else if (clkEn) begin
         if (state_ff == ST_DONE) begin
            incPend_ff <= postInc;
         end else if ((state_ff == ST_READ || state_ff == ST_WRITE) && incPend_ff) begin
            hx_ff <= hx_ff + 16'h0001;
            incPend_ff <= 1'b0;
         end else if (take && cmd == cbcm_pkg::CMD_LOAD && cmdData[1:0] == cbcm_pkg::LD_HX) begin
            hx_ff <= cmdValue;
         end
      end
   end

   // Opcode and operand capture, then a registered decode result.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         page2_ff <= 1'b0;
         ent_ff <= cbcm_pkg::ENTRY_RST;
         opndIdx_ff <= 2'h0;
         opndTot_ff <= 2'h0;
         decValid_ff <= 1'b0;
         decEa_ff <= 16'h0000;
         decTarget_ff <= 16'h0000;
         for (int i = 0; i < cbcm_pkg::OPND_MAX; i++) begin
            opnd_ff[i] <= 8'h00;
         end
      end else if (clkEn) begin
         decValid_ff <= 1'b0;
         if (take && cmd == cbcm_pkg::CMD_FETCH) begin
            page2_ff <= 1'b0;
         end
         if (state_ff == ST_OPC) begin
            if (isPage2Prefix) begin
               page2_ff <= 1'b1;
            end else begin
               ent_ff <= lnk.rdEntry;
               opndTot_ff <= opndCount;
               opndIdx_ff <= 2'h0;
            end
         end
         if (state_ff == ST_OPND) begin
            opnd_ff[opndIdx_ff] <= busRdata;
            opndIdx_ff <= opndIdx_ff + 2'h1;
         end
         if (state_ff == ST_DONE) begin
            decValid_ff <= 1'b1;
            decEa_ff <= lnk.ea;
            decTarget_ff <= lnk.target;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         data_ff <= 8'h00;
         readValid_ff <= 1'b0;
         readData_ff <= 8'h00;
      end else if (clkEn) begin
         readValid_ff <= 1'b0;
         if (take) begin
            data_ff <= cmdData;
         end
         if (state_ff == ST_READ || state_ff == ST_POP) begin
            readValid_ff <= 1'b1;
            readData_ff <= busRdata;
         end
      end
   end

   // Bus view of the current cycle; a free cycle reads at the program counter.
   always_comb begin
      busAddr = pc_ff;
      busRead = 1'b0;
      busWrite = 1'b0;
      case (state_ff)
         ST_OPC, ST_OPND: begin
            busRead = 1'b1;
         end
         ST_FREE: begin
            busRead = 1'b1;
         end
         ST_READ: begin
            busAddr = decEa_ff;
            busRead = 1'b1;
         end
         ST_WRITE: begin
            busAddr = decEa_ff;
            busWrite = 1'b1;
         end
         ST_PUSH: begin
            busAddr = sp_ff;
            busWrite = 1'b1;
         end
         ST_POP: begin
            busAddr = sp_ff + 16'h0001;
            busRead = 1'b1;
         end
         ST_VECHI: begin
            busAddr = {cbcm_pkg::VEC_PAGE, data_ff};
            busRead = 1'b1;
         end
         ST_VECLO: begin
            busAddr = {cbcm_pkg::VEC_PAGE, data_ff + 8'h01};
            busRead = 1'b1;
         end
         default: begin
            busAddr = pc_ff;
         end
      endcase
   end

   assign busWdata = data_ff;
   assign decValid = decValid_ff;
   assign decOpClass = ent_ff.opClass;
   assign decMode = ent_ff.mode;
   assign decLen = ent_ff.len;
   assign decCycles = ent_ff.cycles;
   assign decPage2 = page2_ff;
   assign decEa = decEa_ff;
   assign decTarget = decTarget_ff;
   assign readValid = readValid_ff;
   assign readData = readData_ff;
   assign pcOut = pc_ff;
   assign spOut = sp_ff;
   assign hxOut = hx_ff;

endmodule : cbcm_decode_top

/* File: dv/cbcm_mem_model.sv */
`timescale 1ns/1ps
module cbcm_mem_model (
   input wire logic clock,
   input wire logic [15:0] busAddr,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic [7:0] busWdata,
   output logic [7:0] busRdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] lastRd = 8'h00;
   // Outside a read the data lines show the inverse of the last byte, so a stale sample cannot match.
   assign busRdata = busRead ? mem[busAddr] : ~lastRd;
   always @(posedge clock) begin
      if (busWrite) begin
         mem[busAddr] <= busWdata;
      end
      if (busRead) begin
         lastRd <= mem[busAddr];
      end
   end
endmodule : cbcm_mem_model

/* File: dv/cbcm_decode_asserts.sv */
`timescale 1ns/1ps
module cbcm_decode_asserts (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic cmdValid,
   input wire logic [2:0] cmdKind,
   input wire logic [7:0] cmdData,
   input wire logic cmdReady,
   input wire logic [15:0] busAddr,
   input wire logic busRead,
   input wire logic busWrite,
   input wire logic [7:0] busRdata,
   input wire logic decValid,
   input wire logic [3:0] decMode,
   input wire logic [2:0] decLen,
   input wire logic [15:0] decEa,
   input wire logic [15:0] decTarget,
   input wire logic readValid,
   input wire logic [7:0] readData,
   input wire logic [15:0] pcOut,
   input wire logic [15:0] spOut,
   input wire logic [15:0] hxOut
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   logic take;
   logic [15:0] fetchPc_ff;
   logic [7:0] lastB_ff;
   logic [7:0] prevB_ff;
   assign take = clkEn && cmdValid && cmdReady;
   always_ff @(posedge clock) begin
      if (take && cmdKind == 3'h0) begin
         fetchPc_ff <= pcOut;
      end
   end
   // A decode with operands ends on its final operand read, so the last read byte is the final operand and, with two operands, the one before is the first.
   always_ff @(posedge clock) begin
      if (busRead) begin
         prevB_ff <= lastB_ff;
         lastB_ff <= busRdata;
      end
   end
   sequence s_vec_hi;
      busRead && busAddr == {8'hFF, $past(cmdData)};
   endsequence
   sequence s_vec_lo;
      busRead && busAddr == {8'hFF, $past(cmdData, 2) + 8'h01};
   endsequence
   sequence s_push_wr;
      busWrite && !busRead && busAddr == $past(spOut);
   endsequence
   a_free_read: assert property (take && cmdKind == 3'h6 |=> busRead && !busWrite ##1 !busRead)
      else $error("free cycle is not a single read");
   a_push_write: assert property (take && cmdKind == 3'h3 |=> s_push_wr ##1 !busWrite && spOut == $past(spOut, 2) - 16'h0001)
      else $error("push is not one write at the stack pointer");
   a_pop_read: assert property (take && cmdKind == 3'h4 |=> busRead && busAddr == $past(spOut) + 16'h0001
      ##1 !busRead && readValid && readData == $past(busRdata))
      else $error("pop is not one read above the stack pointer");
   a_vector_order: assert property (take && cmdKind == 3'h5 |=> s_vec_hi ##1 s_vec_lo)
      else $error("vector bytes not read high then low from the top page");
   a_fetch_start: assert property (take && cmdKind == 3'h0 |=> busRead && busAddr == $past(pcOut))
      else $error("fetch does not start at the program counter");
   a_pc_follows: assert property (decValid |-> pcOut == fetchPc_ff + {13'h0000, decLen})
      else $error("program counter does not follow the instruction length");
   a_byte_index: assert property (decValid && decMode == 4'h5 |-> decEa == hxOut + {8'h00, lastB_ff})
      else $error("indexed byte offset address wrong");
   a_word_index: assert property (decValid && decMode == 4'h6 |-> decEa == hxOut + {prevB_ff, lastB_ff})
      else $error("indexed word offset address wrong");
   a_postinc_ea: assert property (decValid && decMode == 4'h7 |-> decEa == hxOut)
      else $error("post-increment address wrong");
   a_offset_postinc: assert property (decValid && decMode == 4'h8 |-> decEa == hxOut + {8'h00, lastB_ff})
      else $error("offset post-increment address wrong");
   a_stack_ea: assert property (decValid && decMode == 4'hA |-> decEa == spOut + {8'h00, lastB_ff})
      else $error("stack byte offset address wrong");
   a_stack_word: assert property (decValid && decMode == 4'hB |-> decEa == spOut + {prevB_ff, lastB_ff})
      else $error("stack word offset address wrong");
   a_rel_target: assert property (decValid && decMode == 4'h9 |-> decTarget == pcOut + {{8{lastB_ff[7]}}, lastB_ff})
      else $error("branch target wrong");
endmodule : cbcm_decode_asserts
bind cbcm_decode_top cbcm_decode_asserts u_asserts (.clock, .reset_n, .clkEn, .cmdValid, .cmdKind, .cmdData,
   .cmdReady, .busAddr, .busRead, .busWrite, .busRdata, .decValid, .decMode, .decLen, .decEa, .decTarget,
   .readValid, .readData, .pcOut, .spOut, .hxOut);

/* File: dv/cpu_bus_cycle_and_mode_decode_tb.sv */
`timescale 1ns/1ps
module cpu_bus_cycle_and_mode_decode_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic clkEn = 1'b1;
   logic tblWrEn = 1'b0;
   logic [8:0] tblWrIdx = 9'h000;
   logic [18:0] tblWrData = 19'h00000;
   logic cmdValid = 1'b0;
   logic [2:0] cmdKind = 3'h0;
   logic [7:0] cmdData = 8'h00;
   logic [15:0] cmdValue = 16'h0000;
   logic cmdReady, busRead, busWrite, decValid, decPage2, readValid;
   logic [15:0] busAddr, decEa, decTarget, pcOut, spOut, hxOut;
   logic [7:0] busWdata, busRdata, decOpClass, readData;
   logic [3:0] decMode, decCycles;
   logic [2:0] decLen;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   cbcm_decode_top uut (.clock, .reset_n, .clkEn, .tblWrEn, .tblWrIdx, .tblWrData, .cmdValid, .cmdKind,
      .cmdData, .cmdValue, .cmdReady, .busAddr, .busRead, .busWrite, .busWdata, .busRdata, .decValid,
      .decOpClass, .decMode, .decLen, .decCycles, .decPage2, .decEa, .decTarget, .readValid, .readData,
      .pcOut, .spOut, .hxOut);
   cbcm_mem_model mm (.clock, .busAddr, .busRead, .busWrite, .busWdata, .busRdata);
   initial begin
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask : chk
   // Returns at the falling edge just after the take edge, while the bus access stands.
   task automatic cmd(input logic [2:0] k, input logic [7:0] d, input logic [15:0] v);
      int n;
      n = 0;
      @(negedge clock);
      while (cmdReady !== 1'b1 && n < 50) begin
         @(negedge clock);
         n++;
      end
      if (n >= 50) begin
         failures++;
         $display("mismatch at %0t: command port never ready", $time);
      end
      cmdValid = 1'b1;
      cmdKind = k;
      cmdData = d;
      cmdValue = v;
      @(negedge clock);
      cmdValid = 1'b0;
   endtask : cmd
   task automatic fetch(input logic p2, input logic [7:0] opc, input logic [3:0] md, input logic [2:0] ln,
                        input logic [15:0] pc, input logic [7:0] o0, input logic [7:0] o1);
      int n;
      n = ln - 1 - p2;
      @(negedge clock);
      tblWrEn = 1'b1;
      tblWrIdx = {p2, opc};
      tblWrData = {opc, md, ln, 4'h3};
      @(negedge clock);
      tblWrEn = 1'b0;
      mm.mem[pc] = p2 ? 8'h9E : opc;
      mm.mem[pc + 16'h0001] = p2 ? opc : o0;
      mm.mem[pc + 16'h0002] = p2 ? o0 : o1;
      mm.mem[pc + 16'h0003] = o1;
      cmd(3'h7, 8'h00, pc);
      cmd(3'h0, 8'h00, 16'h0000);
      repeat (2 + n + p2) @(negedge clock);
      chk(decValid === 1'b1, "decode timing");
      chk(decMode === md && decLen === ln && decPage2 === p2 && decOpClass === opc && decCycles === 4'h3,
          "decode fields");
      chk(pcOut === pc + ln, "pc after fetch");
   endtask : fetch
   task automatic t_index();
      cmd(3'h7, 8'h02, 16'h12F0);
      fetch(1'b0, 8'hE6, 4'h5, 3'h2, 16'h1000, 8'hF0, 8'h00);
      chk(decEa === 16'h13E0, "byte offset ea");
      cmd(3'h2, 8'h3C, 16'h0000);
      @(negedge clock);
      chk(mm.mem[16'h13E0] === 8'h3C, "operand write");
      fetch(1'b0, 8'hD6, 4'h6, 3'h3, 16'h1100, 8'h80, 8'h01);
      chk(decEa === 16'h92F1, "word offset ea");
      fetch(1'b0, 8'hC6, 4'h3, 3'h3, 16'h1200, 8'h12, 8'h34);
      chk(decEa === 16'h1234, "extended ea");
      fetch(1'b0, 8'hB6, 4'h2, 3'h2, 16'h1300, 8'h45, 8'h00);
      chk(decEa === 16'h0045, "direct ea");
      fetch(1'b0, 8'h6E, 4'hE, 3'h3, 16'h1400, 8'h55, 8'h66);
      chk(decEa === 16'h0066, "immediate to direct ea");
      fetch(1'b0, 8'hF6, 4'h4, 3'h1, 16'h1500, 8'h00, 8'h00);
      chk(decEa === 16'h12F0, "indexed no offset ea");
      $display("test index done");
   endtask : t_index
   task automatic t_stack();
      cmd(3'h7, 8'h01, 16'h0200);
      fetch(1'b1, 8'hE6, 4'hA, 3'h3, 16'h2000, 8'h90, 8'h00);
      chk(decEa === 16'h0290, "stack byte ea");
      fetch(1'b1, 8'hD6, 4'hB, 3'h4, 16'h2100, 8'hFF, 8'h10);
      chk(decEa === 16'h0110, "stack word ea");
      cmd(3'h3, 8'hA5, 16'h0000);
      cmd(3'h3, 8'h5A, 16'h0000);
      @(negedge clock);
      chk(mm.mem[16'h0200] === 8'hA5 && mm.mem[16'h01FF] === 8'h5A && spOut === 16'h01FE, "push");
      cmd(3'h4, 8'h00, 16'h0000);
      @(negedge clock);
      chk(readValid === 1'b1 && readData === 8'h5A && spOut === 16'h01FF, "first pop");
      cmd(3'h4, 8'h00, 16'h0000);
      @(negedge clock);
      chk(readData === 8'hA5 && spOut === 16'h0200, "second pop");
      $display("test stack done");
   endtask : t_stack
   task automatic t_rel();
      fetch(1'b0, 8'h20, 4'h9, 3'h2, 16'h4000, 8'h80, 8'h00);
      chk(decTarget === 16'h3F82, "branch back");
      fetch(1'b0, 8'h21, 4'h9, 3'h2, 16'h4010, 8'h7F, 8'h00);
      chk(decTarget === 16'h4091, "branch forward");
      $display("test branch done");
   endtask : t_rel
   task automatic t_postinc();
      cmd(3'h7, 8'h02, 16'h3000);
      mm.mem[16'h3000] = 8'h77;
      mm.mem[16'h3006] = 8'h66;
      fetch(1'b0, 8'h71, 4'h7, 3'h1, 16'h5000, 8'h00, 8'h00);
      chk(decEa === 16'h3000, "postinc ea");
      cmd(3'h1, 8'h00, 16'h0000);
      chk(busRead === 1'b1 && busAddr === 16'h3000, "postinc access");
      repeat (2) @(negedge clock);
      chk(readData === 8'h77 && hxOut === 16'h3001, "postinc bump");
      fetch(1'b0, 8'h61, 4'h8, 3'h2, 16'h5010, 8'h05, 8'h00);
      chk(decEa === 16'h3006, "offset postinc ea");
      cmd(3'h1, 8'h00, 16'h0000);
      repeat (2) @(negedge clock);
      chk(readData === 8'h66 && hxOut === 16'h3002, "offset postinc bump");
      $display("test postinc done");
   endtask : t_postinc
   task automatic t_vector();
      mm.mem[16'hFFFE] = 8'hC3;
      mm.mem[16'hFFFF] = 8'h4D;
      cmd(3'h5, 8'hFE, 16'h0000);
      chk(busRead === 1'b1 && busAddr === 16'hFFFE, "vector high");
      @(negedge clock);
      chk(busRead === 1'b1 && busAddr === 16'hFFFF, "vector low");
      repeat (2) @(negedge clock);
      chk(pcOut === 16'hC34D, "vector pc");
      $display("test vector done");
   endtask : t_vector
   task automatic t_free();
      cmd(3'h7, 8'h00, 16'h6000);
      cmd(3'h6, 8'h00, 16'h0000);
      chk(busRead === 1'b1 && busWrite === 1'b0 && busAddr === 16'h6000, "free read");
      @(negedge clock);
      chk(busRead === 1'b0 && busWrite === 1'b0 && pcOut === 16'h6000, "free one cycle");
      clkEn = 1'b0;
      cmd(3'h7, 8'h00, 16'h7000);
      chk(pcOut === 16'h6000, "frozen by clock enable");
      clkEn = 1'b1;
      $display("test free done");
   endtask : t_free
   initial begin
      repeat (16) @(negedge clock);
      reset_n = 1'b1;
      t_index();
      t_stack();
      t_rel();
      t_postinc();
      t_vector();
      t_free();
      end_sim();
   end
endmodule : cpu_bus_cycle_and_mode_decode_tb
